// >>> core/microstep_pkg.sv
// Purpose: Shared constants for the step and direction microstep sequencer.
// Assumes: 100 MHz hclk, AHB-Lite register access with 32-bit data.
// Notes: Shift codes give the step width as a power of two table entries.
package microstep_pkg;
  localparam int TABLE_SIZE = 1024;
  localparam int POS_W = 10;
  localparam int CNT_W = 21;
  localparam int CLK_MHZ = 100;
  localparam int STST_LIMIT_CYCLES = 1048576;
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_OPEN = 2'h2;
  localparam logic [3:0] SHIFT_FINEST = 4'h0;
  localparam logic [3:0] SHIFT_16 = 4'h4;
  localparam logic [3:0] SHIFT_QUARTER = 4'h6;
  localparam logic [3:0] SHIFT_HALF = 4'h7;
  localparam logic [3:0] SHIFT_FULL = 4'h8;
  localparam logic [9:0] POS_RESET = 10'h000;
  localparam logic [9:0] QUADRANT = 10'h100;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_COIL = 32'h0000_0008;
  localparam logic [31:0] ADDR_INTERVAL = 32'h0000_000C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int ST_POS_LSB = 0;
  localparam int ST_STST_BIT = 16;
  localparam int ST_INDEX_BIT = 17;
  localparam int ST_INTERP_BIT = 18;
  localparam int ST_STANDBY_BIT = 19;
  localparam int ST_SHIFT_LSB = 20;
  localparam int COIL_B_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage

// >>> core/sine_lookup.sv
// Purpose: Turns the microstep position into signed currents for both coils.
// Assumes: Position 0 is the positive zero crossing of the coil A sine.
// Notes: Quarter wave of 17 points with linear blending, amplitude 248.
`timescale 1ns/1ps
module sine_lookup
  import microstep_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [9:0] pos,
  output logic signed [8:0] coil_a,
  output logic signed [8:0] coil_b
);

  function automatic logic [7:0] quarter_pt(input logic [4:0] k);
    logic [7:0] v;
    case (k)
      5'h00: v = 8'h00;
      5'h01: v = 8'h18;
      5'h02: v = 8'h30;
      5'h03: v = 8'h48;
      5'h04: v = 8'h5F;
      5'h05: v = 8'h75;
      5'h06: v = 8'h8A;
      5'h07: v = 8'h9D;
      5'h08: v = 8'hAF;
      5'h09: v = 8'hC0;
      5'h0A: v = 8'hCE;
      5'h0B: v = 8'hDB;
      5'h0C: v = 8'hE5;
      5'h0D: v = 8'hED;
      5'h0E: v = 8'hF3;
      5'h0F: v = 8'hF7;
      default: v = 8'hF8;
    endcase
    return v;
  endfunction

  function automatic logic signed [8:0] sine_of(input logic [9:0] p);
    logic [8:0] q;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [11:0] mix;
    q = p[8] ? 9'h100 - {1'b0, p[7:0]} : {1'b0, p[7:0]};
    lo = quarter_pt(q[8:4]);
    hi = quarter_pt(5'(q[8:4] + 5'h01));
    mix = {lo, 4'h0} + ({4'h0, hi - lo} * {8'h00, q[3:0]});
    return p[9] ? -$signed({1'b0, mix[11:4]}) : $signed({1'b0, mix[11:4]});
  endfunction

  // Both coils follow one table, coil B a quarter period ahead.
  always_ff @(posedge hclk or negedge hresetn) begin // see RULE_01
    if (!hresetn) begin
      coil_a <= 9'h000;
      coil_b <= 9'h000;
    end else begin
      coil_a <= sine_of(pos); // see RULE_07
      coil_b <= sine_of(pos + QUADRANT);
    end
  end

  equal_fullstep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(pos[7:0]) == 8'h80 |-> (coil_a == coil_b || coil_a == -coil_b)
    && coil_a != 9'h000) // see RULE_07
    else $error("Full step currents differ in magnitude.");

endmodule // sine_lookup

// >>> core/microstep_sequencer.sv
// Purpose: Step and direction microstep sequencer with step interpolation.
// Assumes: Pins are synchronous to hclk; tri-state pins arrive encoded.
// Notes: Registers sit on AHB-Lite with zero wait states.
// Contract
// RULE_01: Index a 1024-entry sine table spanning four full steps.
// RULE_02: Each step adds the step width when dir low, subtracts when high.
// RULE_03: Step width doubles per coarser resolution, up to 256 for full step.
// RULE_04: Switching to coarser resolution snaps position to nearest valid step.
// RULE_05: Full step uses only positions 128, 384, 640 and 896.
// RULE_06: Half step offset 64 pitch 128; quarter offset 32 pitch 64.
// RULE_07: Full step positions give equal coil magnitudes near 0.71.
// RULE_08: Decode two tri-state select pins into resolution and interpolation.
// RULE_09: Interpolation splits each step into evenly spaced finest microsteps.
// RULE_10: Microstep spacing saturates at 2^20 clocks; longer means standstill.
// RULE_11: Standstill starts standby reduction only when it is selected.
// RULE_12: Standstill flag sets on a long interval, clears on next step.
// RULE_13: New rate follows after one interval; early step jumps to target.
// RULE_14: Index is active while the position is at the zero point.
// RULE_15: Index lasts as long as the current microstep.
// RULE_16: Reset loads every internal state with its default.
// RULE_17: The controller holds all inputs low while supply cycles.
// RULE_18: Only rising step edges count; step and dir are synchronised.
// RULE_19: The controller keeps step rate at most half the clock.
// RULE_20: Position is a 10-bit counter wrapping in both directions.
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module microstep_sequencer
  import microstep_pkg::*;
#(
  parameter int STST_LIMIT = STST_LIMIT_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic [1:0] res_sel_hi,
  input wire logic [1:0] res_sel_lo,
  input wire logic standby_select_enable_n,
  output logic [9:0] position,
  output logic signed [8:0] coil_a,
  output logic signed [8:0] coil_b,
  output logic index_out,
  output logic standstill,
  output logic standby_reduce
);

  function automatic logic [4:0] decode_cfg(input logic [1:0] hi,
                                            input logic [1:0] lo);
    logic [4:0] r;
    r = {1'b1, SHIFT_16};
    case ({hi, lo})
      {LVL_LOW, LVL_LOW}: r = {1'b0, SHIFT_FULL};
      {LVL_LOW, LVL_HIGH}: r = {1'b0, SHIFT_HALF};
      {LVL_LOW, LVL_OPEN}: r = {1'b1, SHIFT_HALF};
      {LVL_HIGH, LVL_LOW}: r = {1'b0, SHIFT_QUARTER};
      {LVL_HIGH, LVL_HIGH}: r = {1'b0, SHIFT_16};
      {LVL_HIGH, LVL_OPEN}: r = {1'b1, SHIFT_QUARTER};
      {LVL_OPEN, LVL_LOW}: r = {1'b1, SHIFT_16};
      {LVL_OPEN, LVL_HIGH}: r = {1'b1, SHIFT_QUARTER};
      default: r = {1'b1, SHIFT_16};
    endcase
    return r;
  endfunction

  function automatic logic [9:0] width_of(input logic [3:0] sh);
    return 10'(10'h001 << sh);
  endfunction

  function automatic logic [9:0] snap(input logic [9:0] p,
                                      input logic [3:0] sh);
    logic [9:0] w;
    w = width_of(sh);
    return (w == 10'h001) ? p : ((p & ~(w - 10'h001)) | (w >> 1));
  endfunction

  function automatic logic [9:0] move(input logic [9:0] p,
                                      input logic [9:0] w,
                                      input logic down);
    return down ? p - w : p + w;
  endfunction

  logic step_s1;
  logic step_s2;
  logic step_s3;
  logic dir_s1;
  logic dir_s2;
  logic [3:0] cur_shift;
  logic [3:0] applied_shift;
  logic interp;
  logic [9:0] width;
  logic [9:0] target;
  logic [8:0] remaining;
  logic [CNT_W-1:0] interval_cnt;
  logic [CNT_W-1:0] last_interval;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] tick;
  logic [CNT_W-1:0] next_period;
  logic ms_down;
  logic step_edge;
  logic res_change;
  logic coarser;
  logic [31:0] ctrl;
  logic accept;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic [4:0] cfg;

  assign cfg = decode_cfg(res_sel_hi, res_sel_lo);
  assign width = width_of(applied_shift); // see RULE_03
  assign res_change = cur_shift != applied_shift;
  assign coarser = cur_shift > applied_shift;
  assign step_edge = step_s2 && !step_s3 && ctrl[CTRL_ENABLE_BIT];
  assign accept = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = RESP_OKAY;

  always_comb begin
    next_period = interval_cnt >> applied_shift;
    if (next_period == '0) begin
      next_period = CNT_W'(1);
    end
  end

  // Two-stage synchroniser, a third stage finds the rising step edge.
  always_ff @(posedge hclk or negedge hresetn) begin // see RULE_18
    if (!hresetn) begin
      step_s1 <= 1'b0;
      step_s2 <= 1'b0;
      step_s3 <= 1'b0;
      dir_s1 <= 1'b0;
      dir_s2 <= 1'b0;
    end else begin
      step_s1 <= step_in;
      step_s2 <= step_s1;
      step_s3 <= step_s2;
      dir_s1 <= dir_in;
      dir_s2 <= dir_s1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin // see RULE_08
    if (!hresetn) begin
      cur_shift <= SHIFT_FINEST;
      interp <= 1'b0;
    end else begin
      cur_shift <= cfg[3:0];
      interp <= cfg[4];
    end
  end

  // Step interval measurement saturates at the standstill limit.
  always_ff @(posedge hclk or negedge hresetn) begin // see RULE_10
    if (!hresetn) begin
      interval_cnt <= '0;
      last_interval <= '0;
      standstill <= 1'b0;
    end else if (step_edge) begin
      interval_cnt <= CNT_W'(1);
      last_interval <= interval_cnt;
      standstill <= 1'b0; // see RULE_12
    end else if (interval_cnt < CNT_W'(STST_LIMIT)) begin
      interval_cnt <= interval_cnt + CNT_W'(1);
    end else begin
      standstill <= 1'b1; // see RULE_12
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin // see RULE_11
    if (!hresetn) begin
      standby_reduce <= 1'b0;
    end else begin
      standby_reduce <= standstill && !standby_select_enable_n;
    end
  end

  // Position, interpolation target and microstep timer.
  always_ff @(posedge hclk or negedge hresetn) begin // see RULE_16
    if (!hresetn) begin
      position <= POS_RESET;
      target <= POS_RESET;
      applied_shift <= SHIFT_FINEST;
      remaining <= '0;
      period <= CNT_W'(1);
      tick <= '0;
      ms_down <= 1'b0;
    end else if (step_edge) begin
      target <= move(target, width, dir_s2); // see RULE_02
      if (!interp) begin
        position <= move(position, width, dir_s2); // see RULE_20
        remaining <= '0;
      end else begin
        position <= target; // see RULE_13
        remaining <= width[8:0]; // see RULE_09
        period <= next_period; // see RULE_13
        tick <= '0;
        ms_down <= dir_s2;
      end
    end else if (res_change) begin
      applied_shift <= cur_shift;
      if (coarser) begin
        position <= snap(position, cur_shift); // see RULE_04, RULE_05
        target <= snap(position, cur_shift); // see RULE_06
        remaining <= '0;
      end
    end else if (remaining != '0) begin
      if (tick + CNT_W'(1) >= period) begin
        tick <= '0;
        position <= move(position, 10'h001, ms_down); // see RULE_09
        remaining <= remaining - 9'h001;
      end else begin
        tick <= tick + CNT_W'(1);
      end
    end
  end

  // Index follows the microstep that covers the zero point.
  always_ff @(posedge hclk or negedge hresetn) begin // see RULE_14
    if (!hresetn) begin
      index_out <= 1'b0;
    end else if (interp) begin
      index_out <= position == POS_RESET; // see RULE_15
    end else begin
      index_out <= position < width; // see RULE_15
    end
  end

  sine_lookup u_sine (
    .hclk(hclk),
    .hresetn(hresetn),
    .pos(position),
    .coil_a(coil_a),
    .coil_b(coil_b)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= accept && hwrite;
      if (accept) begin
        wr_addr <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_pend && wr_addr == ADDR_CTRL) begin
      ctrl <= hwdata & CTRL_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (accept && !hwrite) begin
      case (haddr)
        ADDR_CTRL: hrdata <= ctrl;
        ADDR_STATUS: begin
          hrdata <= '0;
          hrdata[ST_POS_LSB +: POS_W] <= position;
          hrdata[ST_STST_BIT] <= standstill;
          hrdata[ST_INDEX_BIT] <= index_out;
          hrdata[ST_INTERP_BIT] <= interp;
          hrdata[ST_STANDBY_BIT] <= standby_reduce;
          hrdata[ST_SHIFT_LSB +: 4] <= applied_shift;
        end
        ADDR_COIL: begin
          hrdata <= '0;
          hrdata[8:0] <= coil_a;
          hrdata[COIL_B_LSB +: 9] <= coil_b;
        end
        ADDR_INTERVAL: hrdata <= 32'(last_interval);
        default: hrdata <= '0;
      endcase
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  step_add_a: assert property (step_edge && !interp && !dir_s2 |=>
    position == $past(position) + $past(width)) // see RULE_02
    else $error("Step with dir low did not add the width.");

  step_sub_a: assert property (step_edge && !interp && dir_s2 |=>
    position == $past(position) - $past(width)) // see RULE_02
    else $error("Step with dir high did not subtract the width.");

  width_shift_a: assert property (!res_change |->
    width == 10'(10'h001 << cur_shift) && width <= 10'h100) // see RULE_03
    else $error("Step width does not follow resolution.");

  full_grid_a: assert property (applied_shift == SHIFT_FULL && !interp
    && !$past(res_change) |-> position[7:0] == 8'h80) // see RULE_05
    else $error("Full step left the 45 degree grid.");

  coarse_snap_a: assert property (!step_edge && coarser |=>
    (position & (width - 10'h001)) == (width >> 1)) // see RULE_04
    else $error("Coarser resolution did not snap position.");

  half_grid_a: assert property (!step_edge && coarser
    && cur_shift == SHIFT_HALF |=> position[6:0] == 7'h40) // see RULE_06
    else $error("Half step position off its offset.");

  interp_count_a: assert property (step_edge && interp |=>
    remaining == $past(width[8:0]) && remaining >= 9'h002) // see RULE_09
    else $error("Interpolation did not load its microstep count.");

  period_cap_a: assert property (period <= CNT_W'(STST_LIMIT)
    && period != '0) // see RULE_10
    else $error("Microstep period out of range.");

  stst_set_a: assert property (!step_edge && interval_cnt >=
    CNT_W'(STST_LIMIT) |=> standstill) // see RULE_12
    else $error("Long interval did not flag standstill.");

  stst_clear_a: assert property (step_edge |=> !standstill) // see RULE_12
    else $error("Step edge did not clear standstill.");

  standby_gate_a: assert property (standby_select_enable_n |=>
    !standby_reduce) // see RULE_11
    else $error("Standby reduction without selection.");

  early_jump_a: assert property (step_edge && interp && remaining != '0
    |=> position == $past(target)) // see RULE_13
    else $error("Early step did not jump to the target.");

  index_zero_a: assert property (interp && position == POS_RESET |=>
    index_out) // see RULE_14
    else $error("Index missing at the zero point.");

  edge_sync_a: assert property (step_edge |-> $past(step_in, 2)
    && !$past(step_in, 3)) // see RULE_18
    else $error("Step edge not from a synchronised rising edge.");

endmodule // microstep_sequencer

// >>> testbench/step_controller_model.sv
// Purpose: Step and direction source standing in for the motion controller.
// Assumes: Called right after a rising hclk edge.
// Notes: The caller spaces the steps; one call takes eight clocks.
`timescale 1ns/1ps
module step_controller_model (
  input wire logic hclk,
  output logic step_in,
  output logic dir_in
);
  initial begin
    step_in = 1'h0;
    dir_in = 1'h0;
  end
  // Direction settles three clocks ahead; the pulse is four clocks high.
  task automatic step_once(input logic d);
    dir_in <= d;
    repeat (3) @(posedge hclk);
    step_in <= 1'h1;
    repeat (4) @(posedge hclk);
    step_in <= 1'h0;
    @(posedge hclk);
  endtask
endmodule // step_controller_model

// >>> testbench/microstep_sequencer_tb_top.sv
// Purpose: Self-checking bench for the microstep sequencer.
// Assumes: Zero wait state bus; standstill limit shortened to 1024.
// Notes: Steps come from the controller model.
`timescale 1ns/1ps
module microstep_sequencer_tb_top;
  import microstep_pkg::*;
  localparam int LIMIT = 1024;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [1:0] hresp;
  logic step_in;
  logic dir_in;
  logic [1:0] sel_hi = 2'h0;
  logic [1:0] sel_lo = 2'h0;
  logic stby_n = 1'h0;
  logic [9:0] position;
  logic signed [8:0] coil_a;
  logic signed [8:0] coil_b;
  logic index_out;
  logic standstill;
  logic standby_reduce;
  logic [9:0] last_pos = 10'h000;
  logic [31:0] rd;
  logic [9:0] p;
  int errors = 0;
  int n_checks = 0;
  int moves = 0;
  int m0;
  logic [3:0] sh_t [9] = '{SHIFT_FULL, SHIFT_HALF, SHIFT_HALF,
    SHIFT_QUARTER, SHIFT_16, SHIFT_QUARTER, SHIFT_16, SHIFT_QUARTER,
    SHIFT_16};
  logic [8:0] ip_t = 9'h1e4;

  always #5 hclk = ~hclk;

  microstep_sequencer #(.STST_LIMIT(LIMIT)) i_microstep_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .step_in(step_in), .dir_in(dir_in),
    .res_sel_hi(sel_hi), .res_sel_lo(sel_lo),
    .standby_select_enable_n(stby_n), .position(position),
    .coil_a(coil_a), .coil_b(coil_b), .index_out(index_out),
    .standstill(standstill), .standby_reduce(standby_reduce)
  );

  step_controller_model i_step_controller_model (
    .hclk(hclk), .step_in(step_in), .dir_in(dir_in)
  );

  // Counts single-entry forward moves of the position.
  always @(posedge hclk) begin
    if (position === last_pos + 10'h001) begin
      moves <= moves + 1;
    end
    last_pos <= position;
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    d = hrdata;
    chk("hresp", 32'(RESP_OKAY), 32'(hresp));
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a,
                        input logic [31:0] mask, input logic [31:0] exp);
    ahb(1'h0, a, 32'h0000_0000, rd);
    chk(what, exp, rd & mask);
  endtask

  task automatic chk_pos(input logic [9:0] e, input int w, input logic ix);
    chk("position", 32'(e), 32'(position));
    if (ix) begin
      chk("index_out", 32'(e < w), 32'(index_out));
    end
  endtask

  task automatic chk_coils(input logic [9:0] e);
    chk("coil_a", e[9] ? 32'h0000_0151 : 32'h0000_00af,
        32'(coil_a) & 32'h0000_01ff);
    chk("coil_b", (e[9] ^ e[8]) ? 32'h0000_0151 : 32'h0000_00af,
        32'(coil_b) & 32'h0000_01ff);
  endtask

  task automatic step(input logic d, input int gap);
    i_step_controller_model.step_once(d);
    tick(gap - 8);
  endtask

  task automatic set_res(input logic [1:0] h, input logic [1:0] l);
    sel_hi <= h;
    sel_lo <= l;
    tick(4);
  endtask

  initial begin
    tick(16);
    hresetn <= 1'h1;
    tick(4);
    chk_pos(10'h080, 256, 1'h1);
    chk("standstill", 32'h0000_0000, 32'(standstill));
    rd_chk("ctrl", ADDR_CTRL, 32'hffff_ffff, CTRL_RESET);
    rd_chk("unmapped", 32'h0000_0010, 32'hffff_ffff, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      set_res(2'(i / 3), 2'(i % 3));
      rd_chk("mode", ADDR_STATUS, 32'h00f4_0000,
             {8'h00, sh_t[i], 1'h0, ip_t[i], 18'h0_0000});
    end
    set_res(2'h0, 2'h0);
    p = position;
    chk("grid", 32'h0000_0080, 32'(p & 10'h0ff));
    for (int i = 0; i < 5; i++) begin
      p = (i < 4) ? p + 10'h100 : p - 10'h100;
      step(i == 4, 16);
      chk_pos(p, 256, 1'h1);
      chk_coils(p);
    end
    rd_chk("coil", ADDR_COIL, 32'hffff_ffff, 32'h00af_0151);
    ahb(1'h1, ADDR_CTRL, 32'h0000_0000, rd);
    step(1'h0, 16);
    chk_pos(p, 256, 1'h1);
    ahb(1'h1, ADDR_CTRL, CTRL_RESET, rd);
    set_res(2'h1, 2'h1);
    chk_pos(p, 16, 1'h1);
    p = p + 10'h010;
    step(1'h0, 16);
    chk_pos(p, 16, 1'h1);
    set_res(2'h1, 2'h0);
    p = (p & 10'h3c0) | 10'h020;
    chk_pos(p, 64, 1'h1);
    set_res(2'h0, 2'h1);
    p = (p & 10'h380) | 10'h040;
    chk_pos(p, 128, 1'h1);
    p = p - 10'h080;
    step(1'h1, 16);
    chk_pos(p, 128, 1'h1);
    set_res(2'h2, 2'h2);
    tick(LIMIT + 16);
    chk("standstill", 32'h0000_0001, 32'(standstill));
    chk("reduce", 32'h0000_0001, 32'(standby_reduce));
    rd_chk("status", ADDR_STATUS, 32'h0009_0000,
           32'h0009_0000);
    stby_n <= 1'h1;
    tick(3);
    chk("reduce", 32'h0000_0000, 32'(standby_reduce));
    p = position;
    step(1'h0, 350);
    chk("standstill", 32'h0000_0000, 32'(standstill));
    i_step_controller_model.step_once(1'h0);
    chk_pos(p + 10'h010, 0, 1'h0);
    tick(342);
    step(1'h0, 350);
    m0 = moves;
    step(1'h0, 350);
    chk("moves", 32'h0000_0010, 32'(moves - m0));
    chk_pos(p + 10'h040, 0, 1'h0);
    rd_chk("interval", ADDR_INTERVAL, 32'hffff_ffff,
           32'h0000_015e);
    for (int i = 0; i < 8; i++) begin
      step(1'h0, 350);
    end
    chk_pos(p + 10'h0c0, 1, 1'h1);
    tick(LIMIT + 16);
    chk("standstill", 32'h0000_0001, 32'(standstill));
    chk("reduce", 32'h0000_0000, 32'(standby_reduce));
    hresetn <= 1'h0;
    sel_hi <= 2'h0;
    sel_lo <= 2'h0;
    stby_n <= 1'h0;
    tick(2);
    chk_pos(10'h000, 1, 1'h0);
    chk("index_out", 32'h0000_0000, 32'(index_out));
    chk("standstill", 32'h0000_0000, 32'(standstill));
    hresetn <= 1'h1;
    tick(4);
    chk_pos(10'h080, 256, 1'h1);
    finish_test();
  end

  initial begin
    tick(20000);
    errors++;
    finish_test();
  end
endmodule // microstep_sequencer_tb_top
